// [shared/cmb_pkg.sv]
// Package with the message buffer layout, register map, bus responses and frame builder states.
package cmb_pkg;
	// Buffer word zero field layout.
	localparam int          CMB_W0_STD_HI    = 12;
	localparam int          CMB_W0_STD_LO    = 2;
	localparam int          CMB_W0_RTR_BIT   = 1;
	localparam int          CMB_W0_XID_BIT   = 0;
	localparam logic [15:0] CMB_W0_MASK      = 16'h1FFF;
	// Buffer word one field layout.
	localparam int          CMB_W1_EXT_HI    = 11;
	localparam logic [15:0] CMB_W1_MASK      = 16'h0FFF;
	// Buffer count and buffer index width.
	localparam int          CMB_NBUF         = 8;
	localparam int          CMB_IDX_W        = 3;
	// Register byte offsets on the bus.
	localparam logic [7:0]  CMB_OFF_CTRL     = 8'h00;
	localparam logic [7:0]  CMB_OFF_STATUS   = 8'h04;
	localparam logic [7:0]  CMB_OFF_FRAME_ID = 8'h08;
	localparam logic [7:0]  CMB_OFF_BUF_BASE = 8'h40;
	// Control register fields.
	localparam int          CMB_CTRL_GO_BIT  = 0;
	localparam int          CMB_CTRL_IDX_LO  = 8;
	// Status register fields.
	localparam int          CMB_ST_BUSY_BIT  = 0;
	localparam int          CMB_ST_DONE_BIT  = 1;
	localparam int          CMB_ST_XID_BIT   = 2;
	localparam int          CMB_ST_RTR_BIT   = 3;
	localparam int          CMB_ST_BAD_BIT   = 4;
	// Bus responses.
	localparam logic [1:0]  CMB_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  CMB_RESP_SLVERR  = 2'h2;
	// Frame builder states.
	typedef enum logic [1:0] {CMB_IDLE, CMB_FETCH0, CMB_FETCH1, CMB_BUILD} cmb_state_t;
endpackage

// [hdl/cmb_id_build.sv]
// Frame identifier builder that turns the two buffer words into a frame header.
`timescale 1ns/100ps
module cmb_id_build
	import cmb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        load,
	input  wire logic [15:0] word0,
	input  wire logic [15:0] word1,
	output logic      [28:0] frame_id,
	output logic             ext_fmt,
	output logic             remote_req,
	output logic             srr_bad
);
	logic [10:0] std_identifier;
	logic [11:0] ext_identifier_bits;

	// Field extraction from the stored words.
	assign std_identifier      = word0[CMB_W0_STD_HI:CMB_W0_STD_LO]; // RQ2
	assign ext_identifier_bits = word1[CMB_W1_EXT_HI:0]; // RQ6

	// Registered header; low six extended bits live in a word not held here and read zero.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			frame_id   <= 29'h0000000;
			ext_fmt    <= 1'b0;
			remote_req <= 1'b0;
			srr_bad    <= 1'b0;
		end
		else if (load)
		begin
			ext_fmt <= word0[CMB_W0_XID_BIT]; // RQ5
			if (word0[CMB_W0_XID_BIT])
				frame_id <= {std_identifier, ext_identifier_bits, 6'h00}; // RQ7
			else
				frame_id <= {18'h00000, std_identifier};
			remote_req <= !word0[CMB_W0_XID_BIT] && word0[CMB_W0_RTR_BIT]; // RQ3
			srr_bad    <= word0[CMB_W0_XID_BIT] && !word0[CMB_W0_RTR_BIT]; // RQ4
		end
	end

	a_ext_id_place: assert property (@(posedge clk) disable iff (!rst_b)
		load && word0[0] |=> frame_id[28:18] == $past(word0[12:2])) // RQ7
		else $error("Standard identifier not placed on top of extended id.");
	a_rtr_gate: assert property (@(posedge clk) disable iff (!rst_b)
		load && word0[0] |=> !remote_req) // RQ3
		else $error("Remote request raised for an extended frame.");
	a_std_frame: assert property (@(posedge clk) disable iff (!rst_b)
		load && !word0[0] |=> !ext_fmt && frame_id[10:0] == $past(word0[12:2])) // RQ5
		else $error("Standard frame header wrong.");
	a_ext_bits: assert property (@(posedge clk) disable iff (!rst_b)
		load && word0[0] |=> frame_id[17:6] == $past(word1[11:0])) // RQ6
		else $error("Extended identifier bits misplaced.");
endmodule

// [hdl/cmb_engine.sv]
// Message buffer RAM with AXI4-Lite access and the identifier fetch engine.
`timescale 1ns/100ps
// Function
// RQ1: Buffers are plain RAM words written by software, which picks the buffer used.
// RQ2: Word zero holds the standard identifier in bits 12..2; bits 15..13 read zero.
// RQ3: With standard format, word zero bit 1 set requests remote transmission.
// RQ4: Software must set bit 1 whenever it marks a buffer extended.
// RQ5: Word zero bit 0 chooses extended (one) or standard (zero) identifier.
// RQ6: Word one bits 11..0 hold extended bits 17..6; bits 15..12 read zero.
// RQ7: Extended frames put standard identifier on top, then extended bits 17..0; the code puts zeros in bits 5..0.
module cmb_engine
	import cmb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [28:0]      frame_id,
	output logic             frame_ext,
	output logic             frame_remote,
	output logic             frame_valid
);
	logic [15:0]          buf_mem [0:2*CMB_NBUF-1];
	logic [7:0]           aw_q;
	logic                 aw_have_q;
	logic [31:0]          w_q;
	logic [3:0]           ws_q;
	logic                 w_have_q;
	logic [CMB_IDX_W-1:0] idx_q;
	logic                 done_q;
	logic                 go_pulse;
	cmb_state_t           state_q;
	logic [15:0]          w0_q;
	logic [15:0]          w1_q;
	logic                 srr_bad;
	logic                 do_write;
	logic                 buf_hit_w;
	logic [3:0]           buf_slot_w;
	logic [31:0]          rd_d;
	logic [1:0]           rresp_d;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_have_q && w_have_q;
	assign buf_hit_w     = aw_q >= CMB_OFF_BUF_BASE && aw_q < CMB_OFF_BUF_BASE + 8'(8 * CMB_NBUF);
	assign buf_slot_w    = 4'((aw_q - CMB_OFF_BUF_BASE) >> 2);
	assign go_pulse      = do_write && aw_q == CMB_OFF_CTRL && ws_q[0] && w_q[CMB_CTRL_GO_BIT];
	assign frame_valid   = done_q;

	// Address and data capture in either order.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_q      <= 8'h00;
			w_q       <= 32'h00000000;
			ws_q      <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			else if (do_write)
				aw_have_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				w_q      <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			else if (do_write)
				w_have_q <= 1'b0;
		end
	end

	// Write response; addresses other than the buffers and the control register answer with an error.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CMB_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (buf_hit_w || aw_q == CMB_OFF_CTRL) ? CMB_RESP_OKAY : CMB_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Buffer RAM: software writes words directly; unimplemented top bits are never stored.
	always_ff @(posedge clk)
	begin
		if (do_write && buf_hit_w)
		begin
			if (ws_q[0])
				buf_mem[buf_slot_w][7:0] <= w_q[7:0]; // RQ1
			if (ws_q[1])
				buf_mem[buf_slot_w][15:8] <= w_q[15:8] & (buf_slot_w[0] ? CMB_W1_MASK[15:8] : CMB_W0_MASK[15:8]); // RQ2 RQ6
		end
	end

	// Control register: buffer index chosen by software.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			idx_q <= '0;
		else if (do_write && aw_q == CMB_OFF_CTRL && ws_q[1])
			idx_q <= w_q[CMB_CTRL_IDX_LO +: CMB_IDX_W]; // RQ1
	end

	// Fetch engine reads both words of the selected buffer from RAM.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= CMB_IDLE;
			done_q  <= 1'b0;
			w0_q    <= 16'h0000;
			w1_q    <= 16'h0000;
		end
		else
		begin
			unique case (state_q)
				CMB_IDLE:
				begin
					if (go_pulse)
					begin
						state_q <= CMB_FETCH0;
						done_q  <= 1'b0;
					end
				end
				CMB_FETCH0:
				begin
					w0_q    <= buf_mem[{idx_q, 1'b0}];
					state_q <= CMB_FETCH1;
				end
				CMB_FETCH1:
				begin
					w1_q    <= buf_mem[{idx_q, 1'b1}];
					state_q <= CMB_BUILD;
				end
				CMB_BUILD:
				begin
					done_q  <= 1'b1;
					state_q <= CMB_IDLE;
				end
			endcase
		end
	end

	// Header builder.
	cmb_id_build u_build (
		.clk        (clk),
		.rst_b      (rst_b),
		.load       (state_q == CMB_BUILD),
		.word0      (w0_q),
		.word1      (w1_q),
		.frame_id   (frame_id),
		.ext_fmt    (frame_ext),
		.remote_req (frame_remote),
		.srr_bad    (srr_bad)
	);

	// Read mux; buffer words read with unimplemented bits as zero.
	always_comb
	begin
		rd_d    = 32'h00000000;
		rresp_d = CMB_RESP_OKAY;
		if (s_axi_araddr >= CMB_OFF_BUF_BASE && s_axi_araddr < CMB_OFF_BUF_BASE + 8'(8 * CMB_NBUF))
			rd_d = {16'h0000, buf_mem[4'((s_axi_araddr - CMB_OFF_BUF_BASE) >> 2)]};
		else if (s_axi_araddr == CMB_OFF_CTRL)
			rd_d = {21'h000000, idx_q, 8'h00};
		else if (s_axi_araddr == CMB_OFF_STATUS)
			rd_d = {27'h0000000, srr_bad, frame_remote, frame_ext, done_q, state_q != CMB_IDLE};
		else if (s_axi_araddr == CMB_OFF_FRAME_ID)
			rd_d = {3'h0, frame_id};
		else
			rresp_d = CMB_RESP_SLVERR;
	end

	// Read response register.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= CMB_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_d;
			s_axi_rresp  <= rresp_d;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	a_go_done: assert property (@(posedge clk) disable iff (!rst_b)
		go_pulse && state_q == CMB_IDLE |=> !done_q ##3 done_q) // RQ1
		else $error("Fetch did not finish in four cycles.");
	// Any buffer word read back: address bit 2 tells word zero from word one.
	a_w0_top_zero: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
		$rose(s_axi_rvalid) && $past(s_axi_araddr) >= CMB_OFF_BUF_BASE && $past(s_axi_araddr[2]) == 1'b0
		|-> s_axi_rdata[15:13] == 3'h0)
		else $error("Word zero top bits not zero.");
	a_w1_top_zero: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
		$rose(s_axi_rvalid) && $past(s_axi_araddr) >= CMB_OFF_BUF_BASE && $past(s_axi_araddr[2]) == 1'b1
		|-> s_axi_rdata[15:12] == 4'h0)
		else $error("Word one top bits not zero.");
	a_resp_after: assert property (@(posedge clk) disable iff (!rst_b)
		do_write |=> s_axi_bvalid) // RQ1
		else $error("No write response after write.");
endmodule

// [sim/test_cmb_engine.sv]
// Testbench for the message buffer engine: bus access, field masks and identifier builds.
`timescale 1ns/100ps
module test_cmb_engine
	import cmb_pkg::*;
;
	logic        clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        frame_ext, frame_remote, frame_valid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [28:0] frame_id;
	int          n_mismatch, samples_checked;

	// Device under test, bench signals share the port names.
	cmb_engine u_cmb_engine (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_id,
		.frame_ext, .frame_remote, .frame_valid);

	// Clock of 8 ns period.
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Compares one value and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Byte address of a buffer word.
	function automatic logic [7:0] ba(input int idx, input int w);
		return CMB_OFF_BUF_BASE + 8'(8 * idx + 4 * w);
	endfunction

	// Bus write; handshakes are seen at the falling edge, which holds the values of the next rising edge.
	// It starts on a fresh rising edge so that a strobe lowered by the last call is never raised in the same step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb)
		begin
			@(negedge clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bready & s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
	endtask

	// Bus read, same handshake sampling as the write.
	task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		while (!tr)
		begin
			@(negedge clk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rready & s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
	endtask

	// Fills a buffer, starts a build and judges the frame header.
	task automatic build(input int idx, input logic [15:0] w0, input logic [15:0] w1, input logic [28:0] id,
		input logic ext, input logic rem);
		wr(ba(idx, 0), {16'h0000, w0}, 4'hF, rsp);
		wr(ba(idx, 1), {16'h0000, w1}, 4'hF, rsp);
		wr(CMB_OFF_CTRL, 32'(idx) << CMB_CTRL_IDX_LO | 32'h0000_0001, 4'hF, rsp);
		for (int i = 0; i < 20 && frame_valid !== 1'b1; i++) @(negedge clk);
		chk({31'h0, frame_valid}, 32'h0000_0001);
		chk({3'h0, frame_id}, {3'h0, id});
		chk({30'h0, frame_ext, frame_remote}, {30'h0, ext, rem});
	endtask

	// Field masks, byte lanes and separate buffers.
	task automatic t_mask;
		wr(ba(3, 0), 32'hFFFF_FFFF, 4'hF, rsp);
		chk(32'(rsp), 32'(CMB_RESP_OKAY));
		wr(ba(3, 1), 32'hFFFF_FFFF, 4'hF, rsp);
		wr(ba(4, 0), 32'h0000_A5A5, 4'hF, rsp);
		wr(ba(4, 0), 32'h0000_FF7E, 4'h1, rsp);
		rdw(ba(3, 0), rd, rsp);
		chk(rd, 32'h0000_1FFF);
		rdw(ba(3, 1), rd, rsp);
		chk(rd, 32'h0000_0FFF);
		rdw(ba(4, 0), rd, rsp);
		chk(rd, 32'h0000_057E);
		$display("test masks done");
	endtask

	// Standard and extended builds, with and without the substitute bit.
	task automatic t_frames;
		build(1, 16'h168E, 16'h0000, 29'h0000_05A3, 1'b0, 1'b1);
		build(7, 16'h0004, 16'h0FFF, 29'h0000_0001, 1'b0, 1'b0);
		build(2, 16'h1317, 16'h0ABC, {11'h4C5, 12'hABC, 6'h00}, 1'b1, 1'b0);
		rdw(CMB_OFF_STATUS, rd, rsp);
		chk(rd, 32'h0000_0006);
		rdw(CMB_OFF_CTRL, rd, rsp);
		chk(rd, 32'h0000_0200);
		build(0, 16'h1FFD, 16'h0001, {11'h7FF, 12'h001, 6'h00}, 1'b1, 1'b0);
		rdw(CMB_OFF_STATUS, rd, rsp);
		chk(rd, 32'h0000_0016);
		$display("test frames done");
	endtask

	// Refused accesses answer with a slave error.
	task automatic t_err;
		rdw(8'h3C, rd, rsp);
		chk(32'(rsp), 32'(CMB_RESP_SLVERR));
		wr(CMB_OFF_STATUS, 32'h0000_0000, 4'hF, rsp);
		chk(32'(rsp), 32'(CMB_RESP_SLVERR));
		wr(CMB_OFF_FRAME_ID, 32'h0000_0000, 4'hF, rsp);
		chk(32'(rsp), 32'(CMB_RESP_SLVERR));
		$display("test errors done");
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Cuts a hang short.
	initial
	begin
		#40000;
		n_mismatch++;
		end_of_test();
	end

	// Reset, then the tests in turn.
	initial
	begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_mask();
		t_frames();
		t_err();
		end_of_test();
	end
endmodule
